//--- verilog/lamp_pkg.sv
// Constants and types shared by the status lamp sequencer
`default_nettype none
package lamp_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned LAMP_TEST_MS    = 500;
    localparam int unsigned LAMP_TEST_CYC   = CLK_HZ / 1000 * LAMP_TEST_MS;
    localparam int unsigned HALF_2HZ_CYC    = CLK_HZ / 4;
    localparam int unsigned MAX_NODES       = 32;
    localparam int unsigned NODE_CNT_W      = 7;
    localparam int unsigned TEST_PHASES     = 3;

    typedef enum logic [1:0] {
        PHASE_GREEN,
        PHASE_RED,
        PHASE_OFF
    } test_phase_e;

    typedef enum {
        ST_TEST,
        ST_SYNC,
        ST_RUN
    } seq_state_e;

    // Pattern selected for the status lamp
    typedef enum logic [3:0] {
        PAT_OFF,
        PAT_GREEN,
        PAT_GREEN_1HZ,
        PAT_GREEN_HALF_HZ,
        PAT_GREEN_2HZ,
        PAT_GREEN_1HZ_NOLINK,
        PAT_RED_GREEN_2HZ,
        PAT_RED_1HZ,
        PAT_RED_2HZ,
        PAT_RED
    } pattern_e;
endpackage : lamp_pkg
`default_nettype wire

//--- verilog/blink_if.sv
// Blink phase bundle from the divider to the lamp logic
`default_nettype none
interface blink_if;
    logic ph_2hz;
    logic ph_1hz;
    logic ph_half_hz;
    logic ph_4hz;
    modport src (output ph_2hz, output ph_1hz, output ph_half_hz, output ph_4hz);
    modport dst (input ph_2hz, input ph_1hz, input ph_half_hz, input ph_4hz);
endinterface : blink_if
`default_nettype wire

//--- verilog/blink_divider.sv
// Square-wave blink phases at 4, 2, 1 and 0.5 Hz
`default_nettype none
module blink_divider
    import lamp_pkg::*;
#(
    parameter int unsigned HALF_CYC = HALF_2HZ_CYC
) (
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_restart,
    blink_if.src      blink
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [3:0]  ph_q;
    logic [3:0]  ph_d;

    // Binary chain of toggles keeps every rate at 50 percent duty
    always_comb begin
        cnt_d = cnt_q + 32'h1;
        ph_d  = ph_q;
        if (i_restart) begin
            cnt_d = '0;
            ph_d  = '0;
        end else if (cnt_q >= 32'(HALF_CYC / 2 - 1)) begin
            cnt_d = '0;
            ph_d  = ph_q + 4'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            ph_q  <= '0;
        end else begin
            cnt_q <= cnt_d;
            ph_q  <= ph_d;
        end
    end

    assign blink.ph_4hz     = ph_q[0];
    assign blink.ph_2hz     = ph_q[1];
    assign blink.ph_1hz     = ph_q[2];
    assign blink.ph_half_hz = ph_q[3];
endmodule : blink_divider
`default_nettype wire

//--- verilog/lamp_pattern.sv
// Maps a selected pattern and blink phases to red and green drive
`default_nettype none
module lamp_pattern
    import lamp_pkg::*;
(
    input  wire pattern_e i_pattern,
    blink_if.dst          blink,
    output logic          o_green,
    output logic          o_red
);
    always_comb begin
        o_green = 1'b0;
        o_red   = 1'b0;
        unique case (i_pattern)
            PAT_OFF:              ;
            PAT_GREEN:            o_green = 1'b1;
            PAT_GREEN_1HZ:        o_green = blink.ph_1hz;
            PAT_GREEN_HALF_HZ:    o_green = blink.ph_half_hz;
            PAT_GREEN_2HZ:        o_green = blink.ph_2hz;
            // Short flash at 1 Hz sets it apart from the plain 1 Hz blink
            PAT_GREEN_1HZ_NOLINK: o_green = blink.ph_1hz & blink.ph_2hz;
            PAT_RED_GREEN_2HZ: begin
                o_red   = blink.ph_2hz;
                o_green = ~blink.ph_2hz;
            end
            PAT_RED_1HZ:          o_red = blink.ph_1hz;
            PAT_RED_2HZ:          o_red = blink.ph_2hz;
            PAT_RED:              o_red = 1'b1;
            default:              ;
        endcase
    end
endmodule : lamp_pattern
`default_nettype wire

//--- verilog/node_status_led_sequencer.sv
// Status lamp sequencer for one node of the sensor cascade
// Overview of operation
// - After reset, lamp test lights every lamp in each colour briefly.
// - Lamp test starts on the shared start pulse, in step with all nodes.
// - After test, wait for sync done, then show operating patterns.
// - Steady green when this node, downstream and accessories run error-free.
// - Steady green with channels not both green means this node shut down.
// - Green 1 Hz for downstream shutdown or downstream channel error.
// - Green 0.5 Hz when driver link exists but cascade comms broke.
// - Green 0.5 Hz also when more than 32 nodes sit on one line.
// - Green 2 Hz while initialising and establishing communication.
// - Distinct 1 Hz green flash when comms lost and no driver link.
// - Red/green alternate 2 Hz on node count, type or position error.
// - Red 1 Hz on local error; channel lamps tell the error kind.
// - Own red 2 Hz pattern for critical error on a downstream node.
// - Steady red after local critical error, held until power cycle.
// - Nodes upstream of a fault blink; the faulty node blinks only for a channel error.
// - Lamp shows both communication state and the unit's own state.
// - Error on one channel lamp is discrepancy, on both is sequence.
`default_nettype none
module node_status_led_sequencer
    import lamp_pkg::*;
#(
    parameter int unsigned TEST_CYC  = LAMP_TEST_CYC,
    parameter int unsigned HALF_CYC  = HALF_2HZ_CYC,
    parameter int unsigned MAX_NODE  = MAX_NODES
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_test_start,
    input  wire logic                  i_sync_done,
    input  wire logic                  i_init_active,
    input  wire logic                  i_driver_link,
    input  wire logic                  i_comm_lost,
    input  wire logic [NODE_CNT_W-1:0] i_node_count,
    input  wire logic                  i_config_error,
    input  wire logic                  i_down_shutdown,
    input  wire logic                  i_down_chan_error,
    input  wire logic                  i_down_critical,
    input  wire logic                  i_local_critical,
    input  wire logic                  i_local_shutdown,
    input  wire logic [1:0]            i_chan_on,
    input  wire logic [1:0]            i_chan_error,
    output logic                       o_module_status_lamp_green,
    output logic                       o_module_status_lamp_red,
    output logic [1:0]                 o_chan_lamp_green,
    output logic                       o_discrepancy_error,
    output logic                       o_sequence_error,
    output logic                       o_test_busy
);
    // Two-flop synchronisers for all pin-level inputs
    localparam int unsigned NSYNC = 15 + NODE_CNT_W;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw = {i_test_start, i_sync_done, i_init_active, i_driver_link, i_comm_lost,
                  i_node_count, i_config_error, i_down_shutdown, i_down_chan_error,
                  i_down_critical, i_local_critical, i_local_shutdown,
                  i_chan_on, i_chan_error};

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    logic                  test_start;
    logic                  sync_done;
    logic                  init_active;
    logic                  driver_link;
    logic                  comm_lost;
    logic [NODE_CNT_W-1:0] node_count;
    logic                  config_error;
    logic                  down_shutdown;
    logic                  down_chan_error;
    logic                  down_critical;
    logic                  local_critical;
    logic                  local_shutdown;
    logic [1:0]            chan_on;
    logic [1:0]            chan_error;
    assign {test_start, sync_done, init_active, driver_link, comm_lost, node_count,
            config_error, down_shutdown, down_chan_error, down_critical,
            local_critical, local_shutdown, chan_on, chan_error} = s2_q;

    // Sequencer: lamp test, sync wait, run
    seq_state_e  state_q;
    seq_state_e  state_d;
    test_phase_e phase_q;
    test_phase_e phase_d;
    logic [31:0] tcnt_q;
    logic [31:0] tcnt_d;
    logic        armed_q;
    logic        armed_d;
    logic        crit_q;
    logic        crit_d;

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        tcnt_d  = tcnt_q;
        armed_d = armed_q;
        // Latched until power cycle; only reset clears it
        crit_d  = crit_q | local_critical;
        unique case (state_q)
            ST_TEST: begin
                if (!armed_q) begin
                    // Hold until the common start so all nodes test together
                    if (test_start) begin
                        armed_d = 1'b1;
                        tcnt_d  = '0;
                    end
                end else if (tcnt_q >= 32'(TEST_CYC - 1)) begin
                    tcnt_d = '0;
                    if (phase_q == PHASE_RED) begin
                        phase_d = PHASE_OFF;
                        state_d = ST_SYNC;
                    end else begin
                        phase_d = PHASE_RED;
                    end
                end else begin
                    tcnt_d = tcnt_q + 32'h1;
                end
            end
            ST_SYNC: begin
                if (sync_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: ;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_TEST;
            phase_q <= PHASE_GREEN;
            tcnt_q  <= '0;
            armed_q <= 1'b0;
            crit_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            tcnt_q  <= tcnt_d;
            armed_q <= armed_d;
            crit_q  <= crit_d;
        end
    end

    // Shared divider, restarted with the test so all nodes blink in phase
    blink_if blink ();
    blink_divider #(
        .HALF_CYC (HALF_CYC)
    ) u_div (
        .i_clock   (i_clock),
        .i_rst_b   (i_rst_b),
        .i_restart (state_q == ST_TEST && !armed_q),
        .blink     (blink)
    );

    // Pattern priority
    pattern_e pat;
    logic     too_many;
    assign too_many = node_count > NODE_CNT_W'(MAX_NODE);

    always_comb begin
        // Own state takes precedence over comms, comms over downstream
        if (crit_q) begin
            pat = PAT_RED;
        end else if (|chan_error) begin
            pat = PAT_RED_1HZ;
        end else if (config_error) begin
            pat = PAT_RED_GREEN_2HZ;
        end else if (too_many) begin
            pat = PAT_GREEN_HALF_HZ;
        end else if (comm_lost && driver_link) begin
            pat = PAT_GREEN_HALF_HZ;
        end else if (comm_lost) begin
            pat = PAT_GREEN_1HZ_NOLINK;
        end else if (init_active) begin
            pat = PAT_GREEN_2HZ;
        end else if (down_critical) begin
            pat = PAT_RED_2HZ;
        end else if (down_shutdown || down_chan_error) begin
            // Upstream nodes blink so a shut-down node sits at the first steady lamp
            pat = PAT_GREEN_1HZ;
        end else begin
            // Own shutdown shows on channel lamps, module lamp stays green
            pat = PAT_GREEN;
        end
    end

    logic run_green;
    logic run_red;
    lamp_pattern u_pat (
        .i_pattern (pat),
        .blink     (blink),
        .o_green   (run_green),
        .o_red     (run_red)
    );

    // Output stage
    logic       ms_g_d;
    logic       ms_r_d;
    logic [1:0] ch_g_d;
    logic       disc_d;
    logic       seq_d;
    logic       ms_g_q;
    logic       ms_r_q;
    logic [1:0] ch_g_q;
    logic       disc_q;
    logic       seq_q;
    logic       busy_q;

    always_comb begin
        ms_g_d = 1'b0;
        ms_r_d = 1'b0;
        ch_g_d = 2'b00;
        disc_d = 1'b0;
        seq_d  = 1'b0;
        unique case (state_q)
            ST_TEST: begin
                if (armed_q) begin
                    ms_g_d = (phase_q == PHASE_GREEN);
                    ms_r_d = (phase_q == PHASE_RED);
                    ch_g_d = {2{phase_q == PHASE_GREEN}};
                end
            end
            ST_SYNC: ;
            ST_RUN: begin
                ms_g_d = run_green;
                ms_r_d = run_red;
                disc_d = ^chan_error;
                seq_d  = &chan_error;
                for (int i = 0; i < 2; i++) begin
                    // Faulty channel flashes, healthy one shows its level
                    ch_g_d[i] = chan_error[i] ? blink.ph_4hz : chan_on[i];
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ms_g_q <= 1'b0;
            ms_r_q <= 1'b0;
            ch_g_q <= 2'b00;
            disc_q <= 1'b0;
            seq_q  <= 1'b0;
            busy_q <= 1'b1;
        end else begin
            ms_g_q <= ms_g_d;
            ms_r_q <= ms_r_d;
            ch_g_q <= ch_g_d;
            disc_q <= disc_d;
            seq_q  <= seq_d;
            busy_q <= (state_d != ST_RUN);
        end
    end

    assign o_module_status_lamp_green = ms_g_q;
    assign o_module_status_lamp_red   = ms_r_q;
    assign o_chan_lamp_green          = ch_g_q;
    assign o_discrepancy_error        = disc_q;
    assign o_sequence_error           = seq_q;
    assign o_test_busy                = busy_q;

    a_crit_held: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        crit_q |=> crit_q) else $error("critical latch dropped");
    a_crit_red: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (crit_q && state_q == ST_RUN) |=> (ms_r_q && !ms_g_q))
        else $error("critical error not steady red");
    a_no_run_unsynced: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_SYNC && !sync_done) |=> state_q == ST_SYNC)
        else $error("left sync without done");
    a_test_waits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_TEST && !armed_q) |=> (!ms_g_q && !ms_r_q))
        else $error("lamp lit before common start");
    a_test_green: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(armed_q) |=> (ms_g_q && !ms_r_q))
        else $error("lamp test green phase missing");
    a_seq_both: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_RUN && chan_error == 2'b11) |=> (seq_q && !disc_q))
        else $error("sequence error not flagged");
    a_disc_one: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_RUN && ^chan_error) |=> (disc_q && !seq_q))
        else $error("discrepancy error not flagged");
    a_local_red: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_RUN && !crit_q && |chan_error) |=> !ms_g_q)
        else $error("local error shows green");
    a_cfg_prio: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!crit_q && |chan_error) |-> pat == PAT_RED_1HZ)
        else $error("priority order broken");
    a_steady_green: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_RUN && !crit_q && chan_error == 2'b00 && !config_error
         && !too_many && !comm_lost && !init_active && !down_critical
         && !down_shutdown && !down_chan_error) |=> ms_g_q && !ms_r_q)
        else $error("normal state not steady green");
    // Own shutdown must not dim or redden the module lamp
    a_own_shutdown: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == ST_RUN && local_shutdown && pat == PAT_GREEN) |=> ms_g_q && !ms_r_q)
        else $error("own shutdown changed module lamp");
endmodule : node_status_led_sequencer
`default_nettype wire

//--- sim/lamp_observer.sv
// Operator view of the status lamp: lit cycles and turn-on edges in a window
`default_nettype none
module lamp_observer (
    input  wire logic i_clock,
    input  wire logic i_green,
    input  wire logic i_red
);
    timeunit 1ns;
    timeprecision 100ps;

    // Samples taken just after each edge still see the pre-edge lamp state
    task automatic measure(input int n, output logic [31:0] res, output logic [7:0] amber);
        logic [7:0] ghi;
        logic [7:0] gup;
        logic [7:0] rhi;
        logic [7:0] rup;
        logic       pg;
        logic       pr;
        ghi = 8'h00;
        gup = 8'h00;
        rhi = 8'h00;
        rup = 8'h00;
        amber = 8'h00;
        @(posedge i_clock);
        pg = i_green;
        pr = i_red;
        repeat (n) begin
            @(posedge i_clock);
            if (i_green === 1'b1) ghi++;
            if (i_green === 1'b1 && pg !== 1'b1) gup++;
            if (i_red === 1'b1) rhi++;
            if (i_red === 1'b1 && pr !== 1'b1) rup++;
            // Both colours at once would look like a third colour
            if (i_green === 1'b1 && i_red === 1'b1) amber++;
            pg = i_green;
            pr = i_red;
        end
        res = {ghi, gup, rhi, rup};
    endtask : measure
endmodule : lamp_observer
`default_nettype wire

//--- sim/tb_node_status_led_sequencer.sv
// Self-checking bench for the node status lamp sequencer
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module tb_node_status_led_sequencer
    import lamp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short counts keep the run small: 2 Hz half period is HC cycles
    localparam int TC = 10;
    localparam int HC = 8;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        test_start = 1'b0, sync_done = 1'b0, init_active = 1'b0;
    logic        driver_link = 1'b0, comm_lost = 1'b0, config_error = 1'b0;
    logic        down_shutdown = 1'b0, down_chan_error = 1'b0, down_critical = 1'b0;
    logic        local_critical = 1'b0, local_shutdown = 1'b0;
    logic [6:0]  node_count = 7'h00;
    logic [1:0]  chan_on = 2'h0, chan_error = 2'h0;
    logic        green, red, disc, seq, busy;
    logic [1:0]  chan_green;
    logic [31:0] seed = 32'h1055;
    logic [31:0] res;
    logic [7:0]  amb;
    int          err_total = 0, check_count = 0, cycles = 0, cnt;

    always #5 clock = ~clock;

    node_status_led_sequencer #(.TEST_CYC(TC), .HALF_CYC(HC), .MAX_NODE(MAX_NODES)) dut (
        .i_clock(clock), .i_rst_b(rst_b), .i_test_start(test_start),
        .i_sync_done(sync_done), .i_init_active(init_active),
        .i_driver_link(driver_link), .i_comm_lost(comm_lost),
        .i_node_count(node_count), .i_config_error(config_error),
        .i_down_shutdown(down_shutdown), .i_down_chan_error(down_chan_error),
        .i_down_critical(down_critical), .i_local_critical(local_critical),
        .i_local_shutdown(local_shutdown), .i_chan_on(chan_on),
        .i_chan_error(chan_error), .o_module_status_lamp_green(green),
        .o_module_status_lamp_red(red), .o_chan_lamp_green(chan_green),
        .o_discrepancy_error(disc), .o_sequence_error(seq), .o_test_busy(busy)
    );

    lamp_observer obs (.i_clock(clock), .i_green(green), .i_red(red));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Per 128-cycle window: green lit, green edges, red lit, red edges
    function automatic logic [31:0] exp_pat(input int k);
        case (k)
            0: return 32'h0000_4004;
            1: return 32'h4008_4008;
            2: return 32'h4002_0000;
            3: return 32'h4002_0000;
            4: return 32'h2004_0000;
            5: return 32'h4008_0000;
            6: return 32'h0000_4008;
            7: return 32'h4004_0000;
            8: return 32'h8000_0000;
            default: return 32'h0000_8000;
        endcase
    endfunction : exp_pat

    // Condition k is raised; only lower-priority ones are added at random
    // Odd rounds fault both channels, even rounds exactly one
    task automatic apply(input int k, input int rd);
        logic [8:0]  en;
        logic [31:0] r;
        r = rnd();
        for (int j = 0; j < 9; j++) begin
            en[j] = (j == k) ? 1'b1 : ((j > k) ? r[j] : 1'b0);
        end
        @(posedge clock);
        chan_error <= en[0] ? (rd[0] ? 2'h3 : {r[9], ~r[9]}) : 2'h0;
        config_error <= en[1];
        node_count <= en[2] ? 7'h21 + {2'h0, r[15:11]} :
                      ((k == 8) ? 7'h20 : {2'h0, r[20:16]});
        comm_lost <= en[3] | en[4];
        driver_link <= en[3] | (~en[4] & r[22]);
        init_active <= en[5];
        down_critical <= en[6];
        down_shutdown <= en[7] & r[23];
        down_chan_error <= en[7] & ~r[23];
        local_shutdown <= r[24];
        chan_on <= r[26:25];
    endtask : apply

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        `CHK("reset_busy", 1'b1, busy)
        `CHK("reset_lamp", 2'h0, {green, red})
        rst_b <= 1'b1;
        obs.measure(16, res, amb);
        `CHK("dark_before_start", 32'h0, res)
        @(posedge clock);
        test_start <= 1'b1;
        @(posedge clock);
        test_start <= 1'b0;
        cnt = 0;
        while (green !== 1'b1 && cnt < 20) begin
            @(posedge clock);
            cnt++;
        end
        `CHK("test_chan_lamps", 2'h3, chan_green)
        cnt = 0;
        while (green === 1'b1 && cnt < 100) begin
            @(posedge clock);
            cnt++;
        end
        `CHK("test_green_len", TC, cnt)
        cnt = 0;
        while (red === 1'b1 && cnt < 100) begin
            @(posedge clock);
            cnt++;
        end
        `CHK("test_red_len", TC, cnt)
        init_active <= 1'b1;
        obs.measure(32, res, amb);
        `CHK("sync_dark", 32'h0, res)
        `CHK("sync_busy", 1'b1, busy)
        sync_done <= 1'b1;
        cnt = 0;
        while (busy !== 1'b0 && cnt < 10) begin
            @(posedge clock);
            cnt++;
        end
        `CHK("run_busy", 1'b0, busy)
        for (int rd = 0; rd < 2; rd++) begin
            for (int k = 0; k < 9; k++) begin
                apply(k, rd);
                repeat (10) @(posedge clock);
                obs.measure(128, res, amb);
                `CHK("pattern", exp_pat(k), res)
                `CHK("amber", 8'h00, amb)
                `CHK("chan_kind", {^chan_error, &chan_error}, {disc, seq})
                if (k == 8) begin
                    `CHK("chan_lamps", chan_on, chan_green)
                end
            end
        end
        apply(int'(rnd() % 9), 0);
        local_critical <= 1'b1;
        @(posedge clock);
        local_critical <= 1'b0;
        repeat (10) @(posedge clock);
        obs.measure(128, res, amb);
        `CHK("critical_held", exp_pat(9), res)
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("repower_busy", 1'b1, busy)
        `CHK("repower_lamp", 2'h0, {green, red})
        rst_b <= 1'b1;
        obs.measure(32, res, amb);
        `CHK("repower_dark", 32'h0, res)
        end_of_test();
    end
endmodule : tb_node_status_led_sequencer
`default_nettype wire
